// ==== shared/smc_consts.svh ====
// constants shared by both ends of the servo mode command link
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// object indices
`define SMC_IDX_CTRL     16'h6040
`define SMC_IDX_MODE     16'h6060
`define SMC_IDX_TTRQ     16'h6071
`define SMC_IDX_TPOS     16'h607A
`define SMC_IDX_TVEL     16'h60FF
`define SMC_IDX_ACC      16'h2F00
`define SMC_IDX_DEC      16'h2F01
`define SMC_IDX_RAMP     16'h2F02
`define SMC_IDX_SPDLIM   16'h2F03
`define SMC_IDX_LINKMAP  16'h2F04
`define SMC_IDX_PERIOD   16'h2F05
`define SMC_IDX_STATUS   16'h2F06

// link map fields
`define SMC_LNK_VEL      0
`define SMC_LNK_TRQ      1
`define SMC_LNK_POS      2

// status fields
`define SMC_ST_EN        8
`define SMC_ST_MOV       9

// mode codes
`define SMC_MODE_PP      8'h01
`define SMC_MODE_PV      8'h03
`define SMC_MODE_PT      8'h04
`define SMC_MODE_HOME    8'h06
`define SMC_MODE_CSP     8'h08
`define SMC_MODE_CSV     8'h09
`define SMC_MODE_CST     8'h0A

// control words
`define SMC_CW_SHUTDOWN  16'h0006
`define SMC_CW_SWON      16'h0007
`define SMC_CW_ENOP      16'h000F
`define SMC_CW_START     16'h001F
`define SMC_CW_START_IMM 16'h005F

// display codes
`define SMC_DISP_BASE    8'h80
`define SMC_DISP_IDLE    8'h00

// reset values
`define SMC_RST_MODE     8'h00
`define SMC_RST_CTRL     16'h0000
`define SMC_RST_WORD     32'h0000_0000
`define SMC_RST_LINK     3'h0

`endif

// ==== shared/smc_if.sv ====
// object access link between motion controller and drive
interface smc_if;
    logic        reqValid;
    logic        reqWrite;
    logic        reqCyclic;
    logic [15:0] reqIndex;
    logic [31:0] reqData;
    logic        rspValid;
    logic        rspOk;
    logic [31:0] rspData;
    logic        syncTick;

    // motion controller end
    modport host (
        output reqValid, reqWrite, reqCyclic, reqIndex, reqData, syncTick,
        input  rspValid, rspOk, rspData
    );

    // drive end
    modport drive (
        input  reqValid, reqWrite, reqCyclic, reqIndex, reqData, syncTick,
        output rspValid, rspOk, rspData
    );
endinterface

// ==== shared/smc_pkg.sv ====
// types shared by both ends of the servo mode command link
package smc_pkg;

    // drive power state
    typedef enum logic [1:0] {
        DS_DISABLED,
        DS_READY,
        DS_SWITCHED_ON,
        DS_ENABLED
    } smc_dstate_t;

    // host user commands
    typedef enum logic [2:0] {
        HC_WRITE,
        HC_READ,
        HC_START,
        HC_TARGET,
        HC_STOP
    } smc_hcmd_t;

    // host sequencer state
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_ISSUE,
        HS_DONE
    } smc_hstate_t;

endpackage

// ==== src/smc_drive.sv ====
// drive end: object dictionary, enable sequence, mode display and setpoints
//
// Functional notes
// - mode code 9 selects cyclic velocity
// - mode code 10 selects cyclic torque
// - mode code 1 selects profile position
// - mode code 3 selects profile velocity
// - mode code 4 selects profile torque
// - homing: write mode 6 before enabling
// - control words 6, 7, 15 enable drive
// - profile position: 31 or 95 starts move
// - control word 6 leaves enabled state
// - velocity modes: zero target before shutdown
// - torque modes: zero target before shutdown
// - target torque counts tenths of percent
// - velocity target written only once enabled
// - display 89 cyclic velocity, 8A cyclic torque
// - display 81, 83, 84 for profile modes
// - display 86 in homing mode
// - profile velocity idle while ramps zero
// - profile torque idle while ramp/limit zero
// - direct writes to linked targets refused
// - host sets cycle period before enabling
// - mode code 8 selects cyclic position
`include "smc_consts.svh"
module smc_drive (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // link to motion controller
    smc_if.drive                    link,
    // motion core
    input  wire logic               motionDone,
    output logic        [7:0]       display,
    output logic        [7:0]       activeMode,
    output logic                    enabled,
    output logic                    moving,
    output logic                    moveStart,
    output logic                    motionActive,
    output logic signed [31:0]      posSetpoint,
    output logic signed [31:0]      velSetpoint,
    output logic signed [15:0]      trqSetpoint
);

    smc_pkg::smc_dstate_t state_q;
    logic [15:0] ctrlWord_q;
    logic [7:0]  modeSel_q;
    logic [15:0] tgtTrq_q;
    logic [31:0] tgtPos_q;
    logic [31:0] tgtVel_q;
    logic [31:0] acc_q;
    logic [31:0] dec_q;
    logic [31:0] ramp_q;
    logic [31:0] spdLim_q;
    logic [2:0]  linkMap_q;
    logic [31:0] period_q;
    logic        newTarget_q;
    logic        rspValid_q;
    logic        rspOk_q;
    logic [31:0] rspData_q;
    logic        take;
    logic        known;
    logic        ok;
    logic        linked;
    logic        wrAcc;
    logic        start;
    logic [31:0] rdVal;
    logic [31:0] statusVal;

    // legal mode codes
    function automatic logic legalMode(input logic [7:0] m);
        legalMode = (m == `SMC_MODE_PP) || (m == `SMC_MODE_PV) || (m == `SMC_MODE_PT)
            || (m == `SMC_MODE_HOME) || (m == `SMC_MODE_CSP) || (m == `SMC_MODE_CSV)
            || (m == `SMC_MODE_CST);
    endfunction

    // a request is taken when no answer is standing
    assign take      = link.reqValid && !rspValid_q;
    assign enabled   = (state_q == smc_pkg::DS_ENABLED);
    assign statusVal = {22'h0, moving, enabled, modeSel_q};

    // decode, read mux and write check
    always_comb begin
        known  = 1'b1;
        rdVal  = 32'h0000_0000;
        linked = 1'b0;
        unique case (link.reqIndex)
            `SMC_IDX_CTRL:    rdVal = {16'h0000, ctrlWord_q};
            `SMC_IDX_MODE:    rdVal = {24'h00_0000, modeSel_q};
            `SMC_IDX_TTRQ: begin
                rdVal  = {{16{tgtTrq_q[15]}}, tgtTrq_q};
                linked = linkMap_q[`SMC_LNK_TRQ];
            end
            `SMC_IDX_TPOS: begin
                rdVal  = tgtPos_q;
                linked = linkMap_q[`SMC_LNK_POS];
            end
            `SMC_IDX_TVEL: begin
                rdVal  = tgtVel_q;
                linked = linkMap_q[`SMC_LNK_VEL];
            end
            `SMC_IDX_ACC:     rdVal = acc_q;
            `SMC_IDX_DEC:     rdVal = dec_q;
            `SMC_IDX_RAMP:    rdVal = ramp_q;
            `SMC_IDX_SPDLIM:  rdVal = spdLim_q;
            `SMC_IDX_LINKMAP: rdVal = {29'h0000_0000, linkMap_q};
            `SMC_IDX_PERIOD:  rdVal = period_q;
            `SMC_IDX_STATUS:  rdVal = statusVal;
            default:          known = 1'b0;
        endcase
        ok = known;
        if (known && link.reqWrite) begin
            if (link.reqIndex == `SMC_IDX_STATUS) begin
                ok = 1'b0;
            end else if (link.reqCyclic != linked) begin
                ok = 1'b0;
            end else if (link.reqIndex == `SMC_IDX_MODE && !legalMode(link.reqData[7:0])) begin
                ok = 1'b0;
            end
        end
    end

    assign wrAcc = take && link.reqWrite && ok;
    assign start = wrAcc && link.reqIndex == `SMC_IDX_CTRL && enabled
        && modeSel_q == `SMC_MODE_PP && newTarget_q
        && (link.reqData[15:0] == `SMC_CW_START || link.reqData[15:0] == `SMC_CW_START_IMM);

    // answer, one cycle after the request is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            rspValid_q <= 1'b0;
            rspOk_q    <= 1'b0;
            rspData_q  <= `SMC_RST_WORD;
        end else begin
            rspValid_q <= take;
            if (take) begin
                rspOk_q   <= ok;
                rspData_q <= (ok && !link.reqWrite) ? rdVal : `SMC_RST_WORD;
            end
        end
    end
    assign link.rspValid = rspValid_q;
    assign link.rspOk    = rspOk_q;
    assign link.rspData  = rspData_q;

    // mode and control word objects
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrlWord_q <= `SMC_RST_CTRL;
            modeSel_q  <= `SMC_RST_MODE;
        end else if (wrAcc) begin
            if (link.reqIndex == `SMC_IDX_CTRL) begin
                ctrlWord_q <= link.reqData[15:0];
            end
            if (link.reqIndex == `SMC_IDX_MODE) begin
                modeSel_q <= link.reqData[7:0];
            end
        end
    end

    // target and parameter objects
    always_ff @(posedge clk) begin
        if (srst) begin
            tgtTrq_q  <= `SMC_RST_CTRL;
            tgtPos_q  <= `SMC_RST_WORD;
            tgtVel_q  <= `SMC_RST_WORD;
            acc_q     <= `SMC_RST_WORD;
            dec_q     <= `SMC_RST_WORD;
            ramp_q    <= `SMC_RST_WORD;
            spdLim_q  <= `SMC_RST_WORD;
            linkMap_q <= `SMC_RST_LINK;
            period_q  <= `SMC_RST_WORD;
        end else if (wrAcc) begin
            unique case (link.reqIndex)
                `SMC_IDX_TTRQ:    tgtTrq_q  <= link.reqData[15:0];
                `SMC_IDX_TPOS:    tgtPos_q  <= link.reqData;
                `SMC_IDX_TVEL:    tgtVel_q  <= link.reqData;
                `SMC_IDX_ACC:     acc_q     <= link.reqData;
                `SMC_IDX_DEC:     dec_q     <= link.reqData;
                `SMC_IDX_RAMP:    ramp_q    <= link.reqData;
                `SMC_IDX_SPDLIM:  spdLim_q  <= link.reqData;
                `SMC_IDX_LINKMAP: linkMap_q <= link.reqData[2:0];
                `SMC_IDX_PERIOD:  period_q  <= link.reqData;
                default:          ;
            endcase
        end
    end

    // power state sequence
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= smc_pkg::DS_DISABLED;
        end else if (wrAcc && link.reqIndex == `SMC_IDX_CTRL) begin
            if (link.reqData[15:0] == `SMC_CW_SHUTDOWN) begin
                state_q <= smc_pkg::DS_READY;
            end else if (link.reqData[15:0] == `SMC_CW_SWON
                         && state_q == smc_pkg::DS_READY) begin
                state_q <= smc_pkg::DS_SWITCHED_ON;
            end else if (link.reqData[15:0] == `SMC_CW_ENOP
                         && state_q == smc_pkg::DS_SWITCHED_ON) begin
                state_q <= smc_pkg::DS_ENABLED;
            end
        end
    end

    // pending target flag and move tracking; a set wins over a clear
    always_ff @(posedge clk) begin
        if (srst) begin
            newTarget_q <= 1'b0;
            moving      <= 1'b0;
            moveStart   <= 1'b0;
        end else begin
            newTarget_q <= (wrAcc && link.reqIndex == `SMC_IDX_TPOS) || (newTarget_q && !start);
            moveStart   <= start;
            if (start) begin
                moving <= 1'b1;
            end else if (!enabled) begin
                moving <= 1'b0;
            end else if (motionDone) begin
                moving <= 1'b0;
            end
            if (wrAcc && link.reqIndex == `SMC_IDX_CTRL && link.reqData[15:0] == `SMC_CW_ENOP
                && state_q == smc_pkg::DS_SWITCHED_ON && modeSel_q == `SMC_MODE_HOME) begin
                moving <= 1'b1;
            end
        end
    end

    // mode display, shown while enabled
    always_ff @(posedge clk) begin
        if (srst) begin
            display    <= `SMC_DISP_IDLE;
            activeMode <= `SMC_RST_MODE;
        end else begin
            activeMode <= enabled ? modeSel_q : `SMC_RST_MODE;
            display    <= enabled ? (`SMC_DISP_BASE | modeSel_q) : `SMC_DISP_IDLE;
        end
    end

    // setpoints: cyclic modes sample on the cycle tick, profile velocity and torque follow, profile position loads on move start
    always_ff @(posedge clk) begin
        if (srst || !enabled) begin
            posSetpoint <= `SMC_RST_WORD;
            velSetpoint <= `SMC_RST_WORD;
            trqSetpoint <= `SMC_RST_CTRL;
        end else begin
            unique case (modeSel_q)
                `SMC_MODE_CSP: if (link.syncTick) posSetpoint <= tgtPos_q;
                `SMC_MODE_CSV: if (link.syncTick) velSetpoint <= tgtVel_q;
                `SMC_MODE_CST: if (link.syncTick) trqSetpoint <= tgtTrq_q;
                `SMC_MODE_PV:  velSetpoint <= (acc_q != 32'h0 && dec_q != 32'h0)
                                   ? tgtVel_q : `SMC_RST_WORD;
                `SMC_MODE_PT:  trqSetpoint <= (ramp_q != 32'h0 && spdLim_q != 32'h0)
                                   ? tgtTrq_q : `SMC_RST_CTRL;
                `SMC_MODE_PP:  if (start) posSetpoint <= tgtPos_q;
                default:       ;
            endcase
        end
    end

    // motion request toward the power stage
    assign motionActive = enabled && (moving || velSetpoint != `SMC_RST_WORD
        || trqSetpoint != `SMC_RST_CTRL || (modeSel_q == `SMC_MODE_CSP && posSetpoint != 32'h0));

endmodule

// ==== src/smc_host.sv ====
// motion controller end: mode start, target and shutdown sequences
`include "smc_consts.svh"
module smc_host (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // link to drive
    smc_if.host                     link,
    // user command port
    input  wire logic               cmdValid,
    input  smc_pkg::smc_hcmd_t      cmdKind,
    input  wire logic               cmdCyclic,
    input  wire logic [7:0]         cmdMode,
    input  wire logic [15:0]        cmdIndex,
    input  wire logic [31:0]        cmdData,
    input  wire logic [31:0]        periodCycles,
    output logic                    cmdReady,
    output logic                    doneValid,
    output logic                    doneOk,
    output logic        [31:0]      rdData,
    output logic                    hostEnabled,
    output logic        [7:0]       hostMode
);

    smc_pkg::smc_hstate_t hs_q;
    logic [15:0] sIdx_q [0:4];
    logic [31:0] sDat_q [0:4];
    logic [2:0]  sLen_q;
    logic [2:0]  sPos_q;
    logic        sWrite_q;
    logic        sCyc_q;
    smc_pkg::smc_hcmd_t sKind_q;
    logic [31:0] tickCnt_q;
    logic        isVel;
    logic        isTrq;
    logic        isTgtIdx;

    assign cmdReady  = (hs_q == smc_pkg::HS_IDLE);
    assign doneValid = (hs_q == smc_pkg::HS_DONE);
    assign isVel     = hostMode == `SMC_MODE_CSV || hostMode == `SMC_MODE_PV;
    assign isTrq     = hostMode == `SMC_MODE_CST || hostMode == `SMC_MODE_PT;
    assign isTgtIdx  = cmdIndex == `SMC_IDX_TVEL || cmdIndex == `SMC_IDX_TTRQ
        || cmdIndex == `SMC_IDX_TPOS;

    // communication cycle divider
    always_ff @(posedge clk) begin
        if (srst || periodCycles == 32'h0 || tickCnt_q >= periodCycles - 32'h1) begin
            tickCnt_q <= `SMC_RST_WORD;
        end else begin
            tickCnt_q <= tickCnt_q + 32'h1;
        end
    end
    assign link.syncTick = !srst && periodCycles != 32'h0 && tickCnt_q == periodCycles - 32'h1;

    // request drive from the script
    assign link.reqValid  = (hs_q == smc_pkg::HS_ISSUE);
    assign link.reqWrite  = sWrite_q;
    assign link.reqCyclic = sCyc_q;
    assign link.reqIndex  = sIdx_q[sPos_q];
    assign link.reqData   = sDat_q[sPos_q];

    // command intake and script stepping
    always_ff @(posedge clk) begin
        if (srst) begin
            hs_q     <= smc_pkg::HS_IDLE;
            sLen_q   <= 3'h0;
            sPos_q   <= 3'h0;
            sWrite_q <= 1'b0;
            sCyc_q   <= 1'b0;
            sKind_q  <= smc_pkg::HC_WRITE;
            for (int i = 0; i < 5; i++) begin
                sIdx_q[i] <= 16'h0000;
                sDat_q[i] <= `SMC_RST_WORD;
            end
        end else begin
            unique case (hs_q)
                smc_pkg::HS_IDLE: if (cmdValid) begin
                    sKind_q  <= cmdKind;
                    sPos_q   <= 3'h0;
                    sWrite_q <= (cmdKind != smc_pkg::HC_READ);
                    sCyc_q   <= cmdCyclic && cmdKind == smc_pkg::HC_TARGET;
                    hs_q     <= smc_pkg::HS_ISSUE;
                    sIdx_q[0] <= cmdIndex;
                    sDat_q[0] <= cmdData;
                    sLen_q    <= 3'h1;
                    unique case (cmdKind)
                        smc_pkg::HC_WRITE: if (isTgtIdx) begin
                            hs_q  <= smc_pkg::HS_DONE;
                        end
                        smc_pkg::HC_READ: ;
                        smc_pkg::HC_START: begin
                            sIdx_q[0] <= `SMC_IDX_PERIOD;
                            sDat_q[0] <= periodCycles;
                            sIdx_q[1] <= `SMC_IDX_MODE;
                            sDat_q[1] <= {24'h00_0000, cmdMode};
                            for (int i = 2; i < 5; i++) begin
                                sIdx_q[i] <= `SMC_IDX_CTRL;
                            end
                            sDat_q[2] <= {16'h0000, `SMC_CW_SHUTDOWN};
                            sDat_q[3] <= {16'h0000, `SMC_CW_SWON};
                            sDat_q[4] <= {16'h0000, `SMC_CW_ENOP};
                            sLen_q    <= 3'h5;
                        end
                        smc_pkg::HC_TARGET: begin
                            if (!hostEnabled) begin
                                hs_q  <= smc_pkg::HS_DONE;
                            end
                            sIdx_q[0] <= isVel ? `SMC_IDX_TVEL
                                : (isTrq ? `SMC_IDX_TTRQ : `SMC_IDX_TPOS);
                            sIdx_q[1] <= `SMC_IDX_CTRL;
                            sDat_q[1] <= {16'h0000, `SMC_CW_START};
                            if (hostMode == `SMC_MODE_PP && !cmdCyclic) begin
                                sLen_q <= 3'h2;
                            end
                        end
                        smc_pkg::HC_STOP: begin
                            sIdx_q[0] <= isVel ? `SMC_IDX_TVEL : `SMC_IDX_TTRQ;
                            sDat_q[0] <= `SMC_RST_WORD;
                            sIdx_q[1] <= `SMC_IDX_CTRL;
                            sDat_q[1] <= {16'h0000, `SMC_CW_SHUTDOWN};
                            if (isVel || isTrq) begin
                                sLen_q <= 3'h2;
                            end else begin
                                sIdx_q[0] <= `SMC_IDX_CTRL;
                                sDat_q[0] <= {16'h0000, `SMC_CW_SHUTDOWN};
                            end
                        end
                        default: ;
                    endcase
                end
                smc_pkg::HS_ISSUE: if (link.rspValid) begin
                    if (!link.rspOk || sPos_q == sLen_q - 3'h1) begin
                        hs_q  <= smc_pkg::HS_DONE;
                    end else begin
                        sPos_q <= sPos_q + 3'h1;
                    end
                end
                smc_pkg::HS_DONE: hs_q <= smc_pkg::HS_IDLE;
            endcase
        end
    end

    // outcome and the host's view of the drive
    always_ff @(posedge clk) begin
        if (srst) begin
            doneOk      <= 1'b0;
            rdData      <= `SMC_RST_WORD;
            hostEnabled <= 1'b0;
            hostMode    <= `SMC_RST_MODE;
        end else if (hs_q == smc_pkg::HS_ISSUE && link.rspValid
                     && (!link.rspOk || sPos_q == sLen_q - 3'h1)) begin
            doneOk <= link.rspOk;
            rdData <= link.rspData;
            if (link.rspOk && sKind_q == smc_pkg::HC_START) begin
                hostEnabled <= 1'b1;
                hostMode    <= sDat_q[1][7:0];
            end
            if (sKind_q == smc_pkg::HC_STOP && link.rspOk) begin
                hostEnabled <= 1'b0;
            end
        end else if (hs_q == smc_pkg::HS_IDLE && cmdValid) begin
            doneOk <= 1'b0;
        end
    end

endmodule

// ==== tb/smc_link_props.sv ====
// interface checks for the servo mode command link
`include "smc_consts.svh"
module smc_link_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // host requests
    input wire logic        reqValid,
    input wire logic        reqWrite,
    input wire logic        reqCyclic,
    input wire logic [15:0] reqIndex,
    input wire logic [31:0] reqData,
    input wire logic        syncTick,
    // drive answers
    input wire logic        rspValid,
    input wire logic        rspOk,
    input wire logic [31:0] rspData
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // request taken, mode code known
    logic taken;
    logic legal;
    assign taken = reqValid && !rspValid;
    assign legal = reqData[7:0] inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
    AST_ANSWER_NEXT: assert property (taken |=> rspValid ##1 !rspValid)
        else $error("answer not a single pulse after request");
    AST_REQ_HELD: assert property (taken |=> reqValid && $stable(reqIndex) && $stable(reqData))
        else $error("request changed before answer");
    AST_NO_STRAY_RSP: assert property (rspValid |-> $past(taken))
        else $error("answer without request");
    AST_MODE_OK: assert property (
        taken && reqWrite && !reqCyclic && reqIndex == `SMC_IDX_MODE && legal |=> rspOk)
        else $error("legal mode code refused");
    AST_MODE_BAD: assert property (
        taken && reqWrite && reqIndex == `SMC_IDX_MODE && !legal |=> !rspOk)
        else $error("illegal mode code accepted");
    AST_CTRL_OK: assert property (
        taken && reqWrite && !reqCyclic && reqIndex == `SMC_IDX_CTRL |=> rspOk)
        else $error("control word write refused");
    AST_WRITE_ZERO: assert property (rspValid && $past(reqWrite) |-> rspData == 32'h0)
        else $error("write answer carries data");
    AST_TICK_PULSE: assert property (syncTick |=> !syncTick)
        else $error("sync tick longer than one cycle");
    // main scenarios
    COV_MODE: cover property (taken && reqWrite && reqIndex == `SMC_IDX_MODE);
    COV_ENOP: cover property (taken && reqIndex == `SMC_IDX_CTRL && reqData == 32'hF);
    COV_REFUSE: cover property (rspValid && !rspOk);
endmodule

// ==== tb/tb_servo_mode_command_sequencer.sv ====
// self-checking bench joining host and drive ends of the command link
`include "smc_consts.svh"
module tb_servo_mode_command_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, cmdValid = 1'b0, cmdCyclic = 1'b0, motionDone = 1'b0;
    smc_pkg::smc_hcmd_t cmdKind = smc_pkg::HC_READ;
    logic [7:0] cmdMode = 8'h00, display, activeMode, hostMode;
    logic [15:0] cmdIndex = 16'h0000;
    logic [31:0] cmdData = 32'h0, periodCycles = 32'h10, rdData, lastRd;
    logic cmdReady, doneValid, doneOk, hostEnabled, enabled, moving, moveStart, motionActive;
    logic lastOk;
    logic signed [31:0] posSetpoint, velSetpoint;
    logic signed [15:0] trqSetpoint;
    int err_total = 0, n_tests = 0, nStarts = 0;
    smc_if lnk ();
    smc_host u_smc_host (.clk(clk), .srst(srst), .link(lnk.host), .cmdValid(cmdValid),
        .cmdKind(cmdKind), .cmdCyclic(cmdCyclic), .cmdMode(cmdMode), .cmdIndex(cmdIndex),
        .cmdData(cmdData), .periodCycles(periodCycles), .cmdReady(cmdReady),
        .doneValid(doneValid), .doneOk(doneOk), .rdData(rdData), .hostEnabled(hostEnabled),
        .hostMode(hostMode));
    smc_drive u_smc_drive (.clk(clk), .srst(srst), .link(lnk.drive), .motionDone(motionDone),
        .display(display), .activeMode(activeMode), .enabled(enabled), .moving(moving),
        .moveStart(moveStart), .motionActive(motionActive), .posSetpoint(posSetpoint),
        .velSetpoint(velSetpoint), .trqSetpoint(trqSetpoint));
    smc_link_props u_props (.clk(clk), .srst(srst), .reqValid(lnk.reqValid),
        .reqWrite(lnk.reqWrite), .reqCyclic(lnk.reqCyclic), .reqIndex(lnk.reqIndex),
        .reqData(lnk.reqData), .syncTick(lnk.syncTick), .rspValid(lnk.rspValid),
        .rspOk(lnk.rspOk), .rspData(lnk.rspData));
    // 125 MHz clock
    always #4 clk = ~clk;
    // count move start pulses
    always @(negedge clk) if (moveStart) nStarts++;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask
    // one user command, waits for its completion pulse
    task automatic cmd(input smc_pkg::smc_hcmd_t k, input logic [7:0] m,
                       input logic [15:0] idx, input logic [31:0] d);
        int i;
        @(negedge clk);
        cmdValid = 1'b1;
        cmdKind = k;
        cmdMode = m;
        cmdIndex = idx;
        cmdData = d;
        @(negedge clk);
        cmdValid = 1'b0;
        for (i = 0; i < 200 && doneValid !== 1'b1; i++) @(negedge clk);
        if (i == 200) begin
            err_total++;
            give_verdict();
        end
        lastOk = doneOk;
        lastRd = rdData;
    endtask
    task automatic pulse_done();
        motionDone = 1'b1;
        @(negedge clk);
        motionDone = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // every mode: enable, display code, shutdown
    task automatic t_modes();
        logic [7:0] modes [7] = '{8'h09, 8'h0A, 8'h01, 8'h03, 8'h04, 8'h06, 8'h08};
        foreach (modes[i]) begin
            cmd(smc_pkg::HC_START, modes[i], 16'h0, 32'h0);
            chk("start ok", 32'h1, 32'(lastOk));
            chk("enabled", 32'h1, 32'(enabled));
            chk("display", 32'(`SMC_DISP_BASE | modes[i]), 32'(display));
            chk("active mode", 32'(modes[i]), 32'(activeMode));
            if (modes[i] == `SMC_MODE_HOME) begin
                chk("homing moving", 32'h1, 32'(moving));
                pulse_done();
            end
            cmd(smc_pkg::HC_STOP, 8'h00, 16'h0, 32'h0);
            chk("disabled", 32'h0, 32'(enabled));
            chk("display idle", 32'h0, 32'(display));
        end
    endtask
    // profile position move
    task automatic t_pp();
        cmd(smc_pkg::HC_START, `SMC_MODE_PP, 16'h0, 32'h0);
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h0000_1234);
        chk("pp target", 32'h1234, posSetpoint);
        chk("pp moving", 32'h1, 32'(moving));
        chk("pp start", 32'h1, nStarts);
        pulse_done();
        chk("pp stopped", 32'h0, 32'(moving));
        cmd(smc_pkg::HC_STOP, 8'h00, 16'h0, 32'h0);
    endtask
    // profile velocity held by zero ramps, zeroed on shutdown
    task automatic t_pv();
        cmd(smc_pkg::HC_START, `SMC_MODE_PV, 16'h0, 32'h0);
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h64);
        repeat (4) @(negedge clk);
        chk("pv no ramp", 32'h0, velSetpoint);
        cmd(smc_pkg::HC_WRITE, 8'h00, `SMC_IDX_ACC, 32'h10);
        cmd(smc_pkg::HC_WRITE, 8'h00, `SMC_IDX_DEC, 32'h10);
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h64);
        repeat (4) @(negedge clk);
        chk("pv ramped", 32'h64, velSetpoint);
        chk("pv active", 32'h1, 32'(motionActive));
        cmd(smc_pkg::HC_STOP, 8'h00, 16'h0, 32'h0);
        chk("pv zeroed", 32'h0, velSetpoint);
    endtask
    // cyclic torque setpoint follows target on each tick
    task automatic t_cst();
        cmd(smc_pkg::HC_START, `SMC_MODE_CST, 16'h0, 32'h0);
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h01F4);
        repeat (40) @(negedge clk);
        chk("cst torque", 32'h01F4, 32'(trqSetpoint));
        cmd(smc_pkg::HC_STOP, 8'h00, 16'h0, 32'h0);
        chk("cst zeroed", 32'h0, 32'(trqSetpoint));
    endtask
    // refusals: illegal mode, disabled target, linked target
    task automatic t_refuse();
        cmd(smc_pkg::HC_START, 8'h02, 16'h0, 32'h0);
        chk("bad mode", 32'h0, 32'(lastOk));
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h5);
        chk("target disabled", 32'h0, 32'(lastOk));
        cmd(smc_pkg::HC_WRITE, 8'h00, `SMC_IDX_LINKMAP, 32'h1);
        cmd(smc_pkg::HC_START, `SMC_MODE_PV, 16'h0, 32'h0);
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h5);
        chk("linked refused", 32'h0, 32'(lastOk));
        cmd(smc_pkg::HC_WRITE, 8'h00, `SMC_IDX_LINKMAP, 32'h0);
        cmd(smc_pkg::HC_TARGET, 8'h00, 16'h0, 32'h5);
        chk("unlinked ok", 32'h1, 32'(lastOk));
        cmd(smc_pkg::HC_READ, 8'h00, `SMC_IDX_STATUS, 32'h0);
        chk("status enabled", 32'h1, 32'(lastRd[`SMC_ST_EN]));
        cmd(smc_pkg::HC_STOP, 8'h00, 16'h0, 32'h0);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        srst = 1'b0;
        t_modes();
        t_pp();
        t_pv();
        t_cst();
        t_refuse();
        give_verdict();
    end
endmodule
